/* tcs_pkg.sv */
/*
  shared constants and types for the tone command channel selector.
  assumes a 100 MHz clock and tone presence levels already synchronous.
*/
package tcs_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int SEL_DELAY_MS = 3500;
  localparam int EXE_DELAY_MS = 3500;
  localparam int LATCH_DELAY_US = 50;
  localparam int SEL_DELAY_CYC = SEL_DELAY_MS * (CLK_HZ / 1000);
  localparam int EXE_DELAY_CYC = EXE_DELAY_MS * (CLK_HZ / 1000);
  localparam int LATCH_DELAY_CYC = LATCH_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int FAST_BIT_CYC = 1_000_000;
  localparam int SLOW_ELEM_CYC = 10_000_000;
  localparam int NUM_CH = 18;
  localparam int CODE_BITS = 9;
  localparam int FIFO_DEPTH = 8;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
    logic e;
    logic f;
    logic g;
  } tcs_tones_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PAIR = 3'b001,
    ST_HOLD = 3'b011,
    ST_SELT = 3'b010,
    ST_SELD = 3'b110,
    ST_EXEC = 3'b111,
    ST_ENER = 3'b101,
    ST_DROP = 3'b100
  } tcs_state_t;

  typedef struct packed {
    logic [4:0] chan;
    logic energized;
  } tcs_vv_t;
endpackage

/* tcs_fifo.sv */
/*
  small flip-flop fifo carrying reply requests.
  assumes one clock and synchronous active high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tcs_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 8
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;
  assign o_in_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_ff != '0);
  assign o_out_data = mem_ff[rd_ff];
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
      begin
        mem_ff[wr_ff] <= i_in_data;
        wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop)
        rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

/* tcs_top.sv */
/*
  tone command channel selector: tone decode, latching, delays,
  channel drive and serial verification reply.
  assumes tone levels synchronous to i_mclk and free of detector dropout.
*/
`timescale 1ns/1ps
`default_nettype none
module tcs_top #(
  parameter int SEL_CYC = tcs_pkg::SEL_DELAY_CYC,
  parameter int EXE_CYC = tcs_pkg::EXE_DELAY_CYC,
  parameter int LATCH_CYC = tcs_pkg::LATCH_DELAY_CYC,
  parameter int FAST_CYC = tcs_pkg::FAST_BIT_CYC,
  parameter int SLOW_CYC = tcs_pkg::SLOW_ELEM_CYC,
  parameter bit VOLTAGE_REPLY_MODE = 1'b0,
  parameter bit FAST_MODE = 1'b1
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire tcs_pkg::tcs_tones_t i_tones,
  input wire logic i_data,
  output logic o_tx_mod,
  output logic o_reply_busy,
  output logic o_rx_lock,
  output logic [tcs_pkg::NUM_CH-1:0] o_chan_out,
  output tcs_pkg::tcs_vv_t o_vv
);
  //////////////////////////////////////////////////////////////////////
  // tone group decode
  wire first_group_tone_seen = i_tones.a | i_tones.b | i_tones.c;
  wire second_group_tone_seen = i_tones.d | i_tones.e | i_tones.f;
  wire any_sel = first_group_tone_seen | second_group_tone_seen;
  wire [1:0] abc_cnt = 2'(i_tones.a) + 2'(i_tones.b) + 2'(i_tones.c);
  wire [1:0] def_cnt = 2'(i_tones.d) + 2'(i_tones.e) + 2'(i_tones.f);

  // pair index 0..2 from two of three tones, single index from one tone
  function automatic logic [1:0] pair_idx(input logic x, input logic y, input logic z);
    pair_idx = (x & y) ? 2'd0 : ((x & z) ? 2'd1 : 2'd2);
  endfunction
  function automatic logic [1:0] one_idx(input logic x, input logic y);
    one_idx = x ? 2'd0 : (y ? 2'd1 : 2'd2);
  endfunction

  wire abc_pair = (abc_cnt == 2'd2);
  wire def_pair = (def_cnt == 2'd2);
  wire [1:0] abc_pi = pair_idx(i_tones.a, i_tones.b, i_tones.c);
  wire [1:0] def_pi = pair_idx(i_tones.d, i_tones.e, i_tones.f);
  wire [1:0] abc_si = one_idx(i_tones.a, i_tones.b);
  wire [1:0] def_si = one_idx(i_tones.d, i_tones.e);

  //////////////////////////////////////////////////////////////////////
  // state and latches
  tcs_pkg::tcs_state_t st_ff;
  tcs_pkg::tcs_state_t nxt_st;
  logic hi_grp_ff;
  logic [1:0] pair_ff;
  logic [1:0] single_ff;
  logic [31:0] tmr_ff;
  logic [4:0] chan_ff;
  logic reply_req;
  logic fifo_ready;

  wire single_now = hi_grp_ff ? (abc_cnt == 2'd1) : (def_cnt == 2'd1);
  wire pair_now = hi_grp_ff ? def_pair : abc_pair;
  // channel number = 1 + pair*3 + single (+9 for high group)
  wire [4:0] dec_chan = 5'(pair_ff) * 5'd3 + 5'(single_ff) + 5'd1
                        + (hi_grp_ff ? 5'd9 : 5'd0);
  wire tmr_sel = (tmr_ff >= 32'(SEL_CYC - 1));
  wire tmr_exe = (tmr_ff >= 32'(EXE_CYC - 1));
  wire tmr_lat = (tmr_ff >= 32'(LATCH_CYC - 1));

  always_comb
  begin
    nxt_st = st_ff;
    reply_req = 1'b0;
    case (st_ff)
      tcs_pkg::ST_IDLE:
        if (abc_pair || def_pair) nxt_st = tcs_pkg::ST_PAIR;
      tcs_pkg::ST_PAIR:
        if (!pair_now && !single_now) nxt_st = tcs_pkg::ST_IDLE;
        else if (single_now && tmr_lat) nxt_st = tcs_pkg::ST_HOLD;
      tcs_pkg::ST_HOLD:
        nxt_st = tcs_pkg::ST_SELT;
      tcs_pkg::ST_SELT:
        if (!any_sel) nxt_st = tcs_pkg::ST_IDLE;
        else if (tmr_sel) nxt_st = tcs_pkg::ST_SELD;
      tcs_pkg::ST_SELD:
      begin
        reply_req = ~VOLTAGE_REPLY_MODE;
        nxt_st = tcs_pkg::ST_EXEC;
      end
      tcs_pkg::ST_EXEC:
        if (!any_sel) nxt_st = tcs_pkg::ST_IDLE;
        else if (i_tones.g && tmr_exe) nxt_st = tcs_pkg::ST_ENER;
      tcs_pkg::ST_ENER:
        if (!i_tones.g)
        begin
          reply_req = ~VOLTAGE_REPLY_MODE;
          nxt_st = tcs_pkg::ST_DROP;
        end
      default:
        if (!any_sel && !i_tones.g) nxt_st = tcs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      st_ff <= tcs_pkg::ST_IDLE;
      hi_grp_ff <= 1'b0;
      pair_ff <= 2'd0;
      single_ff <= 2'd0;
      tmr_ff <= '0;
      chan_ff <= 5'd0;
    end
    else
    begin
      st_ff <= nxt_st;
      if (nxt_st != st_ff || (st_ff == tcs_pkg::ST_EXEC && !i_tones.g))
        tmr_ff <= '0;
      else if (st_ff == tcs_pkg::ST_PAIR && !single_now)
        tmr_ff <= '0;
      else
        tmr_ff <= tmr_ff + 32'd1;
      // abc pair blocks high group loading; overlap tolerated
      if (st_ff == tcs_pkg::ST_IDLE && nxt_st == tcs_pkg::ST_PAIR)
      begin
        hi_grp_ff <= ~abc_pair;
        pair_ff <= abc_pair ? abc_pi : def_pi;
      end
      if (st_ff == tcs_pkg::ST_PAIR && single_now)
        single_ff <= hi_grp_ff ? abc_si : def_si;
      if (st_ff == tcs_pkg::ST_HOLD)
        chan_ff <= dec_chan;
      if (nxt_st == tcs_pkg::ST_IDLE)
        chan_ff <= 5'd0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs: lock, channel drive, voltage code
  // one decoded select line per channel output
  logic [tcs_pkg::NUM_CH-1:0] chan_hit;
  for (genvar ch = 0; ch < tcs_pkg::NUM_CH; ch++)
  begin : g_chan
    assign chan_hit[ch] = (chan_ff == 5'(ch + 1));
  end
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      o_rx_lock <= 1'b0;
      o_chan_out <= '0;
      o_vv <= '0;
    end
    else
    begin
      o_rx_lock <= any_sel;
      o_chan_out <= (nxt_st == tcs_pkg::ST_ENER) ? chan_hit : '0;
      o_vv.chan <= (VOLTAGE_REPLY_MODE && nxt_st inside {tcs_pkg::ST_SELD,
                    tcs_pkg::ST_EXEC, tcs_pkg::ST_ENER}) ? chan_ff : 5'd0;
      o_vv.energized <= VOLTAGE_REPLY_MODE && (nxt_st == tcs_pkg::ST_ENER);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // reply request queue, then serial generator
  logic q_valid;
  logic [4:0] q_chan;
  logic gen_take;
  tcs_fifo #(.WIDTH(5), .DEPTH(tcs_pkg::FIFO_DEPTH)) u_fifo (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(reply_req),
    .o_in_ready(fifo_ready),
    .i_in_data(chan_ff),
    .o_out_valid(q_valid),
    .i_out_ready(gen_take),
    .o_out_data(q_chan)
  );

  // frame: sync, 9 code bits twice, sync = 20 slots
  localparam int SLOTS = 2 * tcs_pkg::CODE_BITS + 2;
  logic busy_ff;
  logic [8:0] code_ff;
  logic [4:0] slot_ff;
  logic [1:0] sub_ff;
  logic [31:0] bt_ff;
  assign gen_take = ~busy_ff;
  wire [31:0] unit = FAST_MODE ? 32'(FAST_CYC) : 32'(SLOW_CYC);
  wire [3:0] bidx = (slot_ff <= 5'd9) ? 4'(slot_ff - 5'd1) : 4'(slot_ff - 5'd10);
  wire is_sync = (slot_ff == 5'd0) || (slot_ff == 5'(SLOTS - 1));
  wire code_bit = code_ff[4'd8 - bidx]; // msb first
  // fast: one unit per bit; slow: dot 1 on 3 off, dash 3 on 1 off
  wire [1:0] subs = FAST_MODE ? 2'd0 : 2'd3;
  wire on_now = is_sync ? 1'b1 : (FAST_MODE ? code_bit
                : (code_bit ? (sub_ff != 2'd3) : (sub_ff == 2'd0)));
  wire unit_end = (bt_ff >= unit - 32'd1);

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      busy_ff <= 1'b0;
      code_ff <= '0;
      slot_ff <= '0;
      sub_ff <= '0;
      bt_ff <= '0;
    end
    else if (!busy_ff)
    begin
      if (q_valid)
      begin
        busy_ff <= 1'b1;
        code_ff <= {4'h0, q_chan}; // octal digits are bit triplets
        slot_ff <= '0;
        sub_ff <= '0;
        bt_ff <= '0;
      end
    end
    else if (!unit_end)
      bt_ff <= bt_ff + 32'd1;
    else
    begin
      bt_ff <= '0;
      if (sub_ff != subs && !is_sync)
        sub_ff <= sub_ff + 2'd1;
      else
      begin
        sub_ff <= '0;
        if (slot_ff == 5'(SLOTS - 1))
          busy_ff <= 1'b0;
        else
          slot_ff <= slot_ff + 5'd1;
      end
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      o_tx_mod <= 1'b0;
      o_reply_busy <= 1'b0;
    end
    else
    begin
      o_reply_busy <= busy_ff;
      o_tx_mod <= busy_ff ? on_now : i_data;
    end
  end

  //////////////////////////////////////////////////////////////////////
  a_lock_follows: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    any_sel |=> o_rx_lock) else $error("lock not asserted");
  a_chan_needs_g: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (o_chan_out != '0) |-> $past(i_tones.g)) else $error("channel on without g");
  a_reply_priority: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    !busy_ff |=> o_tx_mod == $past(i_data)) else $error("data not passed");
  a_sel_reply: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (st_ff == tcs_pkg::ST_SELD && !VOLTAGE_REPLY_MODE) |-> reply_req)
    else $error("no selection reply");
  a_drop_reply: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (st_ff == tcs_pkg::ST_ENER && !i_tones.g && !VOLTAGE_REPLY_MODE) |-> reply_req)
    else $error("no deactivation reply");
  a_one_chan: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    $onehot0(o_chan_out)) else $error("multiple channels");
  a_sync_first: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (!busy_ff && q_valid) |=> ##1 o_tx_mod) else $error("no opening sync");
  a_chan_range: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (st_ff == tcs_pkg::ST_SELT) |-> (chan_ff >= 5'd1 && chan_ff <= 5'd18))
    else $error("channel out of range");

  //////////////////////////////////////////////////////////////////////
  // check helpers: tone run lengths and reply frame length
  // slow frame: two one-unit syncs, each code bit four units
  localparam int FRAME_UNITS = FAST_MODE ? SLOTS : 2 + 4 * 2 * tcs_pkg::CODE_BITS;
  wire [31:0] frame_cyc = 32'(FRAME_UNITS) * unit;
  logic [31:0] g_run_ff;
  logic [31:0] sel_run_ff;
  logic [31:0] frm_cyc_ff;
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      g_run_ff <= '0;
      sel_run_ff <= '0;
      frm_cyc_ff <= '0;
    end
    else
    begin
      // saturating, so a long hold never wraps back under the limit
      g_run_ff <= !i_tones.g ? '0
                  : ((g_run_ff >= 32'(EXE_CYC)) ? g_run_ff : g_run_ff + 32'd1);
      sel_run_ff <= !any_sel ? '0
                    : ((sel_run_ff >= 32'(SEL_CYC)) ? sel_run_ff : sel_run_ff + 32'd1);
      frm_cyc_ff <= busy_ff ? frm_cyc_ff + 32'd1 : '0;
    end
  end

  // timing and sequencing checks on what the block drives
  a_queue_room: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    reply_req |-> fifo_ready)
    else $error("reply queue full");
  a_lock_drops: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    !any_sel |=> !o_rx_lock)
    else $error("lock held without tones");
  a_vv_quiet: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    !VOLTAGE_REPLY_MODE |-> (o_vv == '0))
    else $error("voltage code in serial mode");
  a_chan_hold: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    ((o_chan_out != '0) && i_tones.g) |=> (o_chan_out == $past(o_chan_out)))
    else $error("channel dropped while g held");
  a_exe_wait: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (o_chan_out != '0) |-> (g_run_ff >= 32'(EXE_CYC)))
    else $error("channel energized too early");
  a_exec_abort: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (st_ff == tcs_pkg::ST_EXEC && !i_tones.g) |=> (o_chan_out == '0))
    else $error("channel on without execute hold");
  a_sel_wait: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (st_ff == tcs_pkg::ST_SELD) |-> (sel_run_ff >= 32'(SEL_CYC)))
    else $error("selection before delay");
  a_frame_len: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    $fell(busy_ff) |-> (frm_cyc_ff == frame_cyc))
    else $error("reply frame length wrong");
  a_sync_last: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (busy_ff && slot_ff == 5'(SLOTS - 1)) |=> o_tx_mod)
    else $error("no closing sync");
  a_latch_frozen: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (st_ff inside {tcs_pkg::ST_SELD, tcs_pkg::ST_EXEC, tcs_pkg::ST_ENER, tcs_pkg::ST_DROP})
    |-> $stable({hi_grp_ff, pair_ff, single_ff, chan_ff}))
    else $error("latches not frozen");
  a_group_range: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (st_ff inside {tcs_pkg::ST_SELT, tcs_pkg::ST_SELD, tcs_pkg::ST_EXEC, tcs_pkg::ST_ENER})
    |-> (hi_grp_ff ? (chan_ff >= 5'd10) : (chan_ff <= 5'd9)))
    else $error("channel outside its group");
  a_idle_quiet: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (st_ff == tcs_pkg::ST_IDLE) |-> (o_chan_out == '0))
    else $error("channel on while idle");
  a_overlap_ok: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (st_ff == tcs_pkg::ST_PAIR && pair_now && single_now) |=> (st_ff != tcs_pkg::ST_IDLE))
    else $error("overlap aborted command");
endmodule
`default_nettype wire

/* tcs_station.sv */
/*
  station model: tone sequences with pair/single overlap, reply capture.
  assumes fast reply mode and tones sampled on rising i_mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module tcs_station #(
  parameter int FAST_CYC = 4
) (
  input wire logic i_mclk,
  input wire logic i_tx_mod,
  input wire logic i_reply_busy,
  output var tcs_pkg::tcs_tones_t o_tones
);
  localparam logic [6:0] PAIRS [6] = '{7'h60, 7'h50, 7'h30, 7'h0C, 7'h0A, 7'h06};
  logic [6:0] pair_v;
  logic [6:0] single_v;
  initial o_tones = '0;
  task automatic put(input logic [6:0] v);
    @(posedge i_mclk);
    o_tones <= v;
  endtask
  // pair first, single overlaps briefly as the pair fades out
  task automatic select(input int ch);
    int k;
    k = (ch - 1) % 9;
    pair_v = PAIRS[(ch > 9 ? 3 : 0) + k / 3];
    single_v = (ch > 9 ? 7'h40 : 7'h08) >> (k % 3);
    put(pair_v);
    repeat (20) @(posedge i_mclk);
    put(pair_v | single_v);
    repeat (3) @(posedge i_mclk);
    put(single_v);
  endtask
  task automatic exec_on();
    put(single_v | 7'h01);
  endtask
  // execute tone goes first, single tone afterwards
  task automatic exec_off();
    put(single_v);
  endtask
  task automatic finish_cmd();
    put(7'h00);
  endtask
  // mid-slot sampling, so a one-cycle skew between busy and data is harmless
  task automatic capture(output logic [19:0] frm, output logic seen);
    int n;
    seen = 1'b0;
    frm = '0;
    for (n = 0; n < 400 && !seen; n++)
    begin
      @(posedge i_mclk);
      #1;
      seen = i_reply_busy === 1'b1;
    end
    if (seen)
    begin
      repeat (FAST_CYC / 2) @(posedge i_mclk);
      #1;
      for (n = 19; n >= 0; n--)
      begin
        frm[n] = i_tx_mod;
        repeat (FAST_CYC) @(posedge i_mclk);
        #1;
      end
      for (n = 0; n < 10 && i_reply_busy === 1'b1; n++)
        @(posedge i_mclk);
    end
  endtask
endmodule
`default_nettype wire

/* testbench.sv */
/*
  self-checking bench for the tone command channel selector.
  assumes short delay parameters and fast serial reply mode.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int EXE = 50;
  logic clk;
  logic rst;
  logic data;
  tcs_pkg::tcs_tones_t tones;
  logic tx_mod;
  logic busy;
  logic lock;
  logic [17:0] chan;
  tcs_pkg::tcs_vv_t vv;
  int miscompares;
  int checked;
  int chs [4] = '{1, 9, 10, 18};

  // reply mode parameters keep their defaults: serial fast reply is under test
  tcs_top #(.SEL_CYC(50), .EXE_CYC(EXE), .LATCH_CYC(5), .FAST_CYC(4)) DUT (.i_mclk(clk),
    .i_sys_rst(rst),
    .i_tones(tones), .i_data(data), .o_tx_mod(tx_mod), .o_reply_busy(busy),
    .o_rx_lock(lock), .o_chan_out(chan), .o_vv(vv));
  tcs_station #(.FAST_CYC(4)) st (.i_mclk(clk), .i_tx_mod(tx_mod),
    .i_reply_busy(busy), .o_tones(tones));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic t_lock();
    for (int i = 1; i < 7; i++)
    begin
      st.put(7'h01 << i);
      tick(2);
      check("lock", lock, 1);
      st.put(7'h00);
      tick(2);
      check("lock off", lock, 0);
    end
    st.put(7'h01);
    tick(2);
    check("lock on g", lock, 0);
    st.put(7'h00);
  endtask
  task automatic t_data();
    @(posedge clk);
    data <= 1'b1;
    tick(1);
    check("tx data", tx_mod, 1);
    @(posedge clk);
    data <= 1'b0;
    tick(1);
    check("tx data", tx_mod, 0);
    @(posedge clk);
    data <= 1'b1;
  endtask
  // a pair with no single tone must never latch or reply
  task automatic t_abort();
    logic [19:0] frm;
    logic seen;
    st.put(7'h60);
    tick(20);
    st.finish_cmd();
    st.capture(frm, seen);
    check("abort reply", seen, 0);
    check("abort chan", chan, 0);
  endtask
  // data held high, so zero code bits show the reply overriding it
  task automatic t_cmd(input int ch);
    logic [19:0] frm;
    logic seen;
    logic [8:0] code;
    int n;
    code = 9'(ch);
    st.select(ch);
    tick(2);
    check("lock", lock, 1);
    st.capture(frm, seen);
    check("select reply", frm, {1'b1, code, code, 1'b1});
    st.exec_on();
    tick(EXE - 5);
    check("early chan", chan, 0);
    for (n = 0; n < 15 && chan === 18'h0; n++)
      tick(1);
    check("chan", chan, 18'h1 << (ch - 1));
    check("exe delay", n, 5);
    tick(30);
    check("held chan", chan, 18'h1 << (ch - 1));
    check("vv", vv, 0);
    st.exec_off();
    st.capture(frm, seen);
    check("drop reply", frm, {1'b1, code, code, 1'b1});
    check("drop chan", chan, 0);
    check("tx data", tx_mod, 1);
    st.finish_cmd();
    tick(5);
    check("off chan", chan, 0);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
  initial
  begin
    rst = 1'b1;
    data = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    check("reset", {tx_mod, busy, lock, chan, vv}, 0);
    t_lock();
    t_data();
    t_abort();
    foreach (chs[i])
      t_cmd(chs[i]);
    end_of_test();
  end
endmodule
`default_nettype wire
